// ---- hw/lsl_lamp_driver.sv ----
// link status lamp driver: two groups of four active-low lamps
//
// Strobed register access and the register addresses were decided locally.
module lsl_lamp_driver #(
  parameter int HALF_CYCLES = lsl_pkg::HALF_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // strap and link status
  input  wire logic       lamp_mode_strap,
  input  wire logic [3:0] link0_sync,
  input  wire logic [3:0] link0_traffic,
  input  wire logic [3:0] link1_sync,
  input  wire logic [3:0] link1_traffic,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // lamps
  output logic      [3:0] link0_lamp_n,
  output logic      [3:0] link1_lamp_n
);
  typedef enum logic [1:0] {ST_CATCH = 2'b00, ST_RUN = 2'b01} lsl_state_t;

  lsl_state_t  state_r, state_nxt;
  logic        mode_r, mode_nxt;
  logic [lsl_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic        blink_r, blink_nxt;
  logic        sw_en_r, sw_en_nxt;
  logic [7:0]  sw_lamp_r, sw_lamp_nxt;
  logic [7:0]  rdata_nxt;
  logic [7:0]  lamp_r, lamp_nxt;
  logic [15:0] s1_r, s2_r, s3_r;
  logic [15:0] stat_r, stat_nxt;
  logic [15:0] raw;

  assign raw = {link1_traffic, link1_sync, link0_traffic, link0_sync};

  // per-pair lamp level from sync, traffic and blink phase
  function automatic logic pair_lamp(input logic sy, input logic tr, input logic ph);
    if (!sy) return 1'b1;
    if (tr)  return 1'b0;
    return ph;
  endfunction

  // three-stage pin sampling; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
      s3_r <= 16'h0000;
    end else if (clk_en) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_comb begin
    stat_nxt = stat_r;
    for (int i = 0; i < 16; i++) begin
      if (s2_r[i] == s3_r[i]) stat_nxt[i] = s3_r[i];
    end
  end

  // mode strap caught on the first enabled edge after reset release
  always_comb begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    unique case (state_r)
      ST_CATCH: begin
        mode_nxt  = lamp_mode_strap;
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
      end
      default: state_nxt = ST_CATCH;
    endcase
  end

  // shared blink divider; a slow lamp is acceptable, a stall is not
  always_comb begin
    cnt_nxt   = cnt_r + lsl_pkg::CNT_W'(1);
    blink_nxt = blink_r;
    if (cnt_r >= lsl_pkg::CNT_W'(HALF_CYCLES - 1)) begin
      cnt_nxt   = '0;
      blink_nxt = ~blink_r;
    end
  end

  // register port
  always_comb begin
    sw_en_nxt   = sw_en_r;
    sw_lamp_nxt = sw_lamp_r;
    rdata_nxt   = 8'h00;
    if (reg_wr) begin
      if (reg_addr == lsl_pkg::ADDR_CTRL) sw_en_nxt = reg_wdata[lsl_pkg::CTRL_SW_EN];
      if (reg_addr == lsl_pkg::ADDR_LAMP_SW) sw_lamp_nxt = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        lsl_pkg::ADDR_CTRL:    rdata_nxt = {6'h00, mode_r, sw_en_r};
        lsl_pkg::ADDR_LAMP_SW: rdata_nxt = sw_lamp_r;
        lsl_pkg::ADDR_STATUS:  rdata_nxt = lamp_r;
        default:               rdata_nxt = 8'h00;
      endcase
    end
  end

  // lamp levels
  always_comb begin
    logic [3:0] sy0, tr0, sy1, tr1;
    sy0 = stat_r[3:0];
    tr0 = stat_r[7:4];
    sy1 = stat_r[11:8];
    tr1 = stat_r[15:12];
    lamp_nxt = {lsl_pkg::LAMP_OFF, lsl_pkg::LAMP_OFF};
    if (state_r != ST_RUN) begin
      lamp_nxt = {lsl_pkg::LAMP_OFF, lsl_pkg::LAMP_OFF};
    end else if (sw_en_r) begin
      lamp_nxt = sw_lamp_r;
    end else if (!mode_r) begin
      for (int i = 0; i < 4; i++) begin
        lamp_nxt[i]   = pair_lamp(sy0[i], tr0[i], blink_r);
        lamp_nxt[4+i] = pair_lamp(sy1[i], tr1[i], blink_r);
      end
    end else begin
      // link counts as synced when any pair is; upper lamps stay off
      lamp_nxt[3:1] = 3'h7;
      lamp_nxt[7:5] = 3'h7;
      lamp_nxt[0] = pair_lamp(|sy0, |(sy0 & tr0), blink_r);
      lamp_nxt[4] = pair_lamp(|sy1, |(sy1 & tr1), blink_r);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= ST_CATCH;
      mode_r    <= lsl_pkg::MODE_RST;
      cnt_r     <= '0;
      blink_r   <= 1'b1;
      sw_en_r   <= 1'b0;
      sw_lamp_r <= lsl_pkg::LAMP_SW_RST;
      reg_rdata <= 8'h00;
      lamp_r    <= {lsl_pkg::LAMP_OFF, lsl_pkg::LAMP_OFF};
      stat_r    <= 16'h0000;
    end else if (clk_en) begin
      state_r   <= state_nxt;
      mode_r    <= mode_nxt;
      cnt_r     <= cnt_nxt;
      blink_r   <= blink_nxt;
      sw_en_r   <= sw_en_nxt;
      sw_lamp_r <= sw_lamp_nxt;
      reg_rdata <= rdata_nxt;
      lamp_r    <= lamp_nxt;
      stat_r    <= stat_nxt;
    end
  end

  assign link0_lamp_n = lamp_r[3:0];
  assign link1_lamp_n = lamp_r[7:4];

  // checks
  pair_off_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && !sw_en_r && !mode_r && !stat_r[0]
    |=> link0_lamp_n[0]) else $error("unsynced pair lamp not off");
  far_pair_off_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && !sw_en_r && !mode_r && !stat_r[10]
    |=> link1_lamp_n[2]) else $error("unsynced pair lamp not off");
  pair_on_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && !sw_en_r && !mode_r && stat_r[8] && stat_r[12]
    |=> !link1_lamp_n[0]) else $error("active pair lamp not on");
  pair_blink_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && !sw_en_r && !mode_r && stat_r[1] && !stat_r[5]
    |=> link0_lamp_n[1] == $past(blink_r)) else $error("idle pair not blinking");
  link_upper_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && !sw_en_r && mode_r
    |=> link0_lamp_n[3:1] == 3'h7 && link1_lamp_n[3:1] == 3'h7)
    else $error("upper lamps lit in link mode");
  link_on_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && !sw_en_r && mode_r && |(stat_r[3:0] & stat_r[7:4])
    |=> !link0_lamp_n[0]) else $error("active link lamp not on");
  link_off_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && !sw_en_r && mode_r && stat_r[11:8] == 4'h0
    |=> link1_lamp_n[0]) else $error("unsynced link lamp not off");
  link_blink_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && !sw_en_r && mode_r && |stat_r[3:0]
    && (stat_r[3:0] & stat_r[7:4]) == 4'h0
    |=> link0_lamp_n[0] == $past(blink_r)) else $error("idle link not blinking");
  sw_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_RUN && sw_en_r
    |=> {link1_lamp_n, link0_lamp_n} == $past(sw_lamp_r)) else $error("software lamps ignored");
  // readback shows the lamp levels that stood at the read edge
  status_read_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && reg_rd && reg_addr == lsl_pkg::ADDR_STATUS
    |=> reg_rdata == $past({link1_lamp_n, link0_lamp_n}))
    else $error("status readback wrong");
  read_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && !reg_rd |=> reg_rdata == 8'h00) else $error("read data held too long");
  mode_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    state_r == ST_RUN |=> $stable(mode_r)) else $error("mode changed after catch");
  strap_catch_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && state_r == ST_CATCH
    |=> state_r == ST_RUN && mode_r == $past(lamp_mode_strap)) else $error("strap not caught");
  // the phase turns only on the last count of each half period
  blink_step_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && cnt_r != lsl_pkg::CNT_W'(HALF_CYCLES - 1) |=> $stable(blink_r))
    else $error("blink moved early");
  blink_turn_a: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && cnt_r == lsl_pkg::CNT_W'(HALF_CYCLES - 1) |=> blink_r != $past(blink_r))
    else $error("blink did not turn");
  groups_a: assert property (@(posedge clk) disable iff (!nrst)
    state_r != ST_RUN |-> {link1_lamp_n, link0_lamp_n} == 8'hff) else $error("lamps lit early");
endmodule

// ---- hw/lsl_pkg.sv ----
// constants and register map for the link status lamp driver
package lsl_pkg;
  localparam int          CLK_HZ        = 125_000_000;
  localparam int          BLINK_MS      = 500;
  // half of the blink period, in cycles (toggle every half period)
  localparam int          HALF_CYCLES   = (CLK_HZ / 1000) * BLINK_MS / 2;
  localparam int          CNT_W         = 25;
  localparam logic [3:0]  LAMP_OFF      = 4'hf;
  localparam logic        MODE_RST      = 1'b0;
  // register offsets
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_LAMP_SW  = 4'h4;
  localparam logic [3:0]  ADDR_STATUS   = 4'h8;
  // control fields
  localparam int          CTRL_SW_EN    = 0;
  localparam logic [7:0]  LAMP_SW_RST   = 8'hff;
endpackage

// ---- tb/lsl_lamp_driver_tb_top.sv ----
// self-checking bench for the link status lamp driver
module lsl_lamp_driver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, strap = 1'b0;
  logic [3:0] s0 = 4'h0, t0 = 4'h0, s1 = 4'h0, t1 = 4'h0, reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, lit;
  logic       reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] l0, l1;
  int         miscompares = 0, checks = 0;
  always #4 clk = ~clk;
  // short blink so a full period fits in a few dozen cycles
  lsl_lamp_driver #(.HALF_CYCLES(8)) dut_u (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .lamp_mode_strap(strap),
    .link0_sync(s0), .link0_traffic(t0), .link1_sync(s1), .link1_traffic(t1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link0_lamp_n(l0), .link1_lamp_n(l1));
  lsl_lamp_model lamp_u (.drive_n({l1, l0}), .lit(lit));
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask
  task rst(input logic m);
    @(posedge clk) nrst <= 1'b0;
    strap <= m;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task pins(input logic [15:0] v);
    @(posedge clk) {s1, t1, s0, t0} <= v;
    repeat (10) @(posedge clk);
    #1;
  endtask
  // toggles of lamp i over 32 cycles; lamp j must share its phase
  task blink(input int i, input int j);
    logic p;
    int   n;
    n = 0;
    p = lit[i];
    repeat (32) begin
      @(posedge clk) #1;
      if (lit[i] !== p) n++;
      p = lit[i];
      chk({7'h00, lit[j]}, {7'h00, lit[i]});
    end
    chk(8'(n), 8'h04);
  endtask
  task pair_mode;
    rst(1'b0);
    chk({l1, l0}, 8'hff);
    pins({4'h9, 4'h1, 4'h3, 4'h1});
    chk({2'h0, l1[2:0], l0[3:2], l0[0]}, 8'h36);
    blink(1, 7);
    rd(lsl_pkg::ADDR_CTRL, 8'h00);
  endtask
  task software;
    rd(lsl_pkg::ADDR_LAMP_SW, lsl_pkg::LAMP_SW_RST);
    rd(4'hc, 8'h00);
    wr(lsl_pkg::ADDR_LAMP_SW, 8'h5a);
    wr(lsl_pkg::ADDR_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({l1, l0}, 8'h5a);
    rd(lsl_pkg::ADDR_STATUS, 8'h5a);
    wr(4'hc, 8'h00);
    rd(lsl_pkg::ADDR_LAMP_SW, 8'h5a);
    wr(lsl_pkg::ADDR_CTRL, 8'h00);
  endtask
  // clock enable low: blink phase frozen and a write not taken
  task freeze;
    logic [7:0] held;
    @(posedge clk) clk_en <= 1'b0;
    #1 held = lit;
    wr(lsl_pkg::ADDR_LAMP_SW, 8'h00);
    repeat (20) @(posedge clk);
    #1 chk(lit, held);
    @(posedge clk) clk_en <= 1'b1;
    rd(lsl_pkg::ADDR_LAMP_SW, lsl_pkg::LAMP_SW_RST);
  endtask
  task link_mode;
    pins(16'h0000);
    rst(1'b1);
    rd(lsl_pkg::ADDR_CTRL, 8'h02);
    pins({4'h2, 4'h2, 4'h4, 4'h0});
    chk({1'h0, l1, l0[3:1]}, 8'h77);
    blink(0, 0);
    freeze();
    pins({4'h0, 4'h2, 4'h1, 4'h1});
    chk({l1, l0}, 8'hfe);
    rd(lsl_pkg::ADDR_STATUS, 8'hfe);
  endtask
  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    pair_mode();
    software();
    link_mode();
    conclude();
  end
endmodule

// ---- tb/lsl_lamp_model.sv ----
// external indicator lamps: each lamp lights while its line is low
module lsl_lamp_model (
  // lamp drive lines
  input  wire logic [7:0] drive_n,
  // lamp state
  output logic      [7:0] lit
);
  timeunit 1ns;
  timeprecision 1ps;
  assign lit = ~drive_n;
endmodule
